// ===== common/sgmv_pkg.sv
// package: constants and types of the segment buffer move block
package sgmv_pkg;
    // ------------------------------------------------------------
    // entry array geometry
    // ------------------------------------------------------------
    localparam int SGMV_NENT = 16;
    localparam int SGMV_IW = 4;
    localparam int SGMV_VIRTUAL_SEGMENT_ID_W = 52;
    // ------------------------------------------------------------
    // register-file field positions (bit 0 = msb of the 64-bit word)
    // ------------------------------------------------------------
    localparam int SRC_KEYS_LSB = 29;   // big-endian bits 32-34
    localparam int SRC_NX_LSB = 27;     // big-endian bits 35-36
    localparam int SRC_VLO_LSB = 0;     // big-endian bits 37-63
    localparam int SRC_VLO_W = 27;
    localparam int SRC_VHI_LSB = 32;    // big-endian bits 7-31
    localparam int SRC_VHI_W = 25;
    localparam int IDX_SEL_LSB = 28;    // big-endian bits 32-35
    localparam int RD_ZERO_LSB = 57;    // big-endian bits 0-6
    // ------------------------------------------------------------
    // apb map, byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_MASK = 8'h08;
    localparam logic [7:0] ADDR_CREATED = 8'h0c;
    localparam logic [7:0] ADDR_VICTIM = 8'h10;
    localparam int CTRL_STV_BIT = 0;
    localparam int ST_ILLEGAL = 0;
    localparam int ST_PRIV = 1;
    localparam int ST_UNDEF = 2;
    localparam int ST_W = 3;
    localparam logic [ST_W-1:0] STATUS_RST = 3'h0;
    localparam logic [ST_W-1:0] MASK_RST = 3'h0;
    // ------------------------------------------------------------
    // operation codes and entry layout
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_RD_DIR = 3'b000,
        OP_RD_IDX = 3'b001,
        OP_WR_DIR = 3'b010,
        OP_WR_IDX = 3'b011,
        OP_WRD_DIR = 3'b100,
        OP_WRD_IDX = 3'b101
    } sgmv_op_t;
    typedef struct packed {
        logic [SGMV_IW-1:0] effective_segment_id_lo;
        logic valid;
        logic [2:0] keys;
        logic [1:0] nx;
        logic [SGMV_VIRTUAL_SEGMENT_ID_W-1:0] virtual_segment_id;
    } sgmv_entry_t;
endpackage : sgmv_pkg

// ===== rtl/sgmv_repl_hist.sv
// module: replacement history of the segment buffer
`timescale 1ns/1ns
module sgmv_repl_hist #(
    parameter int IW = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic touch,
    input wire logic [IW-1:0] touch_idx,
    output logic [IW-1:0] victim
);
    import sgmv_pkg::*;
    typedef struct packed {
        logic [IW-1:0] victim;
    } sgmv_hist_t;
    sgmv_hist_t st_reg;
    sgmv_hist_t st_next;
    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // round robin: the victim moves just past the entry last loaded
    always_comb begin
        st_next = st_reg;
        if (touch) begin
            st_next.victim = touch_idx + IW'(1);
        end
    end
    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // synchronous reset to entry zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign victim = st_reg.victim;
endmodule : sgmv_repl_hist

// ===== rtl/sgmv_seg_move.sv
// module: segment buffer move operations with apb status and control
// Operation
// - Indexed read maps entry keys, nx and both virtual_segment_id halves into destination bits.
// - Every read forces destination bits 0 to 6 to zero.
// - Reads of entries not made by a segment write return undefined data.
// - Direct 32-bit write: effective_segment_id from index, valid set, upper virtual_segment_id cleared.
// - 32-bit writes take keys, nx and lower virtual_segment_id from source bits 32-63.
// - Indexed 32-bit write selects entry by index bits 32-35, same mapping.
// - Double-word writes map any segment 0-15 onto the full 52-bit range.
// - Direct double-word write takes upper virtual_segment_id from source bits 7-31, valid set.
// - Indexed double-word write selects entry by index bits 32-35.
// - Double-word writes come as a pair; absent ones raise illegal instruction.
// - Double-word writes on a 32-bit implementation raise illegal instruction.
// - All operations are supervisor only; user attempts are privilege violations.
// - 32-bit reads return the whole entry, double-word entries included.
// - Sixteen entries addressed by a 4-bit index act as segment registers.
// - Reads may be undefined once table translation validity was set.
// - Every segment write updates replacement history like a table reload.
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
module sgmv_seg_move #(
    parameter bit IMPL64 = 1'b1,
    parameter bit DW_PRESENT = 1'b1
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic OP_VALID,
    input wire sgmv_pkg::sgmv_op_t OP_CODE,
    input wire logic OP_SUPER,
    input wire logic [sgmv_pkg::SGMV_IW-1:0] OP_SEG_INDEX,
    input wire logic [63:0] OP_SOURCE_GPR,
    input wire logic [63:0] OP_INDEX_GPR,
    output logic OP_DONE,
    output logic [63:0] OP_RESULT,
    output logic OP_RESULT_DEFINED,
    output logic OP_ILLEGAL,
    output logic OP_PRIV,
    input wire logic RELOAD_TOUCH,
    input wire logic [sgmv_pkg::SGMV_IW-1:0] RELOAD_INDEX,
    output logic [sgmv_pkg::SGMV_IW-1:0] VICTIM_INDEX,
    output logic SEG_TABLE_VALID,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic IRQ
);
    import sgmv_pkg::*;
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        // the sixteen segment registers first, then bookkeeping and results
        sgmv_entry_t [SGMV_NENT-1:0] ent;
        logic [SGMV_NENT-1:0] created;
        logic stv;
        logic [ST_W-1:0] status;
        logic [ST_W-1:0] mask;
        logic [31:0] prdata;
        logic done;
        logic [63:0] result;
        logic defined;
        logic ill;
        logic priv;
    } sgmv_state_t;
    sgmv_state_t st_reg;
    sgmv_state_t st_next;
    logic [SGMV_IW-1:0] sel;
    logic is_read;
    logic is_write;
    logic is_dw;
    logic is_indexed;
    logic known_op;
    logic illegal;
    logic priv_fault;
    logic do_read;
    logic do_write;
    sgmv_entry_t new_ent;
    sgmv_entry_t rd_ent;
    logic [63:0] rd_word;
    logic [ST_W-1:0] ev;
    logic [ST_W-1:0] w1c;
    logic apb_setup;
    logic apb_wr;
    logic mapped;
    logic [SGMV_IW-1:0] victim;
    // ------------------------------------------------------------
    // operation decode
    // ------------------------------------------------------------
    // classify the opcode and pick the entry index
    always_comb begin
        is_read = 1'b0;
        is_write = 1'b0;
        is_dw = 1'b0;
        is_indexed = 1'b0;
        known_op = 1'b1;
        case (OP_CODE)
            OP_RD_DIR: begin
                is_read = 1'b1;
            end
            OP_RD_IDX: begin
                is_read = 1'b1;
                is_indexed = 1'b1;
            end
            OP_WR_DIR: begin
                is_write = 1'b1;
            end
            OP_WR_IDX: begin
                is_write = 1'b1;
                is_indexed = 1'b1;
            end
            OP_WRD_DIR: begin
                is_write = 1'b1;
                is_dw = 1'b1;
            end
            OP_WRD_IDX: begin
                is_write = 1'b1;
                is_dw = 1'b1;
                is_indexed = 1'b1;
            end
            default: begin
                known_op = 1'b0;
            end
        endcase
    end
    // indexed forms take the entry number from index gpr bits 32-35
    assign sel = is_indexed ? OP_INDEX_GPR[IDX_SEL_LSB +: SGMV_IW]
                            : OP_SEG_INDEX;
    // ------------------------------------------------------------
    // exception checks
    // ------------------------------------------------------------
    // illegal instruction outranks the privilege check
    // a double-word write is illegal on a 32-bit build or when the pair is left out
    assign illegal = !known_op || (is_dw && (!IMPL64 || !DW_PRESENT));
    assign priv_fault = !illegal && !OP_SUPER;
    assign do_read = OP_VALID && is_read && !illegal && !priv_fault;
    assign do_write = OP_VALID && is_write && !illegal && !priv_fault;
    // ------------------------------------------------------------
    // entry build for writes
    // ------------------------------------------------------------
    // fill the entry as a segment table load would; unused bits are not stored
    always_comb begin
        new_ent = '0;
        new_ent.effective_segment_id_lo = sel;
        new_ent.valid = 1'b1;
        new_ent.keys = OP_SOURCE_GPR[SRC_KEYS_LSB +: 3];
        new_ent.nx = OP_SOURCE_GPR[SRC_NX_LSB +: 2];
        new_ent.virtual_segment_id[SRC_VLO_W-1:0] = OP_SOURCE_GPR[SRC_VLO_LSB +: SRC_VLO_W];
        // source bits 0-6 are don't-care and never looked at
        if (is_dw) begin
            new_ent.virtual_segment_id[SGMV_VIRTUAL_SEGMENT_ID_W-1:SRC_VLO_W] =
                OP_SOURCE_GPR[SRC_VHI_LSB +: SRC_VHI_W];
        end else begin
            new_ent.virtual_segment_id[SGMV_VIRTUAL_SEGMENT_ID_W-1:SRC_VLO_W] = '0;
        end
    end
    // ------------------------------------------------------------
    // read formatting
    // ------------------------------------------------------------
    // the whole entry goes back, whichever write made it
    assign rd_ent = st_reg.ent[sel];
    // pack the selected entry back into the register-file word
    always_comb begin
        rd_word = '0;
        rd_word[63:RD_ZERO_LSB] = '0;
        rd_word[SRC_VHI_LSB +: SRC_VHI_W] = rd_ent.virtual_segment_id[SGMV_VIRTUAL_SEGMENT_ID_W-1:SRC_VLO_W];
        rd_word[SRC_KEYS_LSB +: 3] = rd_ent.keys;
        rd_word[SRC_NX_LSB +: 2] = rd_ent.nx;
        rd_word[SRC_VLO_LSB +: SRC_VLO_W] = rd_ent.virtual_segment_id[SRC_VLO_W-1:0];
    end
    // ------------------------------------------------------------
    // interrupt events and apb decode
    // ------------------------------------------------------------
    // sticky events: illegal, privilege, undefined read-back
    always_comb begin
        ev = '0;
        ev[ST_ILLEGAL] = OP_VALID && illegal;
        ev[ST_PRIV] = OP_VALID && priv_fault;
        ev[ST_UNDEF] = do_read && !st_reg.created[sel];
    end
    // apb phase and address decode
    assign apb_setup = PSEL && !PENABLE;
    assign apb_wr = PSEL && PENABLE && PWRITE;
    assign mapped = (PADDR == ADDR_CTRL) || (PADDR == ADDR_STATUS) ||
                    (PADDR == ADDR_MASK) || (PADDR == ADDR_CREATED) ||
                    (PADDR == ADDR_VICTIM);
    assign w1c = (apb_wr && PADDR == ADDR_STATUS) ? PWDATA[ST_W-1:0] : '0;
    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // completion pulses, entry updates, status and apb registers
    always_comb begin
        st_next = st_reg;
        st_next.done = OP_VALID;
        st_next.ill = OP_VALID && illegal;
        st_next.priv = OP_VALID && priv_fault;
        // read results are held until the next successful read; writes and refused operations leave them
        if (do_read) begin
            st_next.result = rd_word;
            st_next.defined = st_reg.created[sel];
        end
        if (do_write) begin
            st_next.ent[sel] = new_ent;
            st_next.created[sel] = 1'b1;
        end
        // hardware reloads may replace entries while table translation is on
        if (st_reg.stv) begin
            st_next.created = '0;
        end
        // status: set wins over a write-one clear in the same cycle
        st_next.status = (st_reg.status & ~w1c) | ev;
        if (apb_wr && PADDR == ADDR_CTRL) begin
            st_next.stv = PWDATA[CTRL_STV_BIT];
        end
        if (apb_wr && PADDR == ADDR_MASK) begin
            st_next.mask = PWDATA[ST_W-1:0];
        end
        // read data is fetched in the setup cycle for a zero-wait access
        if (apb_setup) begin
            st_next.prdata = '0;
            case (PADDR)
                ADDR_CTRL: begin
                    st_next.prdata[CTRL_STV_BIT] = st_reg.stv;
                end
                ADDR_STATUS: begin
                    st_next.prdata[ST_W-1:0] = st_reg.status;
                end
                ADDR_MASK: begin
                    st_next.prdata[ST_W-1:0] = st_reg.mask;
                end
                ADDR_CREATED: begin
                    st_next.prdata[SGMV_NENT-1:0] = st_reg.created;
                end
                ADDR_VICTIM: begin
                    st_next.prdata[SGMV_IW-1:0] = victim;
                end
                default: begin
                    st_next.prdata = '0;
                end
            endcase
        end
    end
    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // synchronous reset; entries come up empty and not created
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            st_reg <= '0;
            st_reg.status <= STATUS_RST;
            st_reg.mask <= MASK_RST;
        end else begin
            st_reg <= st_next;
        end
    end
    // ------------------------------------------------------------
    // replacement history
    // ------------------------------------------------------------
    // a segment write touches history exactly as a table reload does
    sgmv_repl_hist #(
        .IW(SGMV_IW)
    ) u_hist (
        .clk(CLOCK),
        .rst_n(RST_N),
        .touch(do_write || RELOAD_TOUCH),
        .touch_idx(do_write ? sel : RELOAD_INDEX),
        .victim(victim)
    );
    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // the operation outputs, SEG_TABLE_VALID and PRDATA come straight from the state register; IRQ and PSLVERR are decoded
    assign OP_DONE = st_reg.done;
    assign OP_RESULT = st_reg.result;
    assign OP_RESULT_DEFINED = st_reg.defined;
    assign OP_ILLEGAL = st_reg.ill;
    assign OP_PRIV = st_reg.priv;
    assign VICTIM_INDEX = victim;
    assign SEG_TABLE_VALID = st_reg.stv;
    assign PRDATA = st_reg.prdata;
    assign PREADY = 1'b1; // never waits
    assign PSLVERR = PSEL && PENABLE && !mapped; // unmapped address
    assign IRQ = |(st_reg.status & st_reg.mask);
endmodule : sgmv_seg_move

// ===== bench/sgmv_seg_move_properties.sv
// checker: port-level properties of the segment move block
`timescale 1ns/1ns
module sgmv_checker import sgmv_pkg::*; #(
    parameter bit IMPL64 = 1'b1,
    parameter bit DW_PRESENT = 1'b1
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic OP_VALID,
    input wire sgmv_pkg::sgmv_op_t OP_CODE,
    input wire logic OP_SUPER,
    input wire logic [sgmv_pkg::SGMV_IW-1:0] OP_SEG_INDEX,
    input wire logic [63:0] OP_SOURCE_GPR,
    input wire logic OP_DONE,
    input wire logic [63:0] OP_RESULT,
    input wire logic OP_ILLEGAL,
    input wire logic OP_PRIV,
    input wire logic [sgmv_pkg::SGMV_IW-1:0] VICTIM_INDEX
);
    // single clock domain, reset quiets every property
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);
    a_done_next: assert property (OP_VALID |=> OP_DONE)
        else $error("operation not answered one cycle later");
    a_idle_quiet: assert property (!OP_VALID |=> !(OP_DONE || OP_ILLEGAL || OP_PRIV))
        else $error("completion flag without a request");
    a_read_top_zero: assert property (OP_RESULT[63:57] == 7'h00)
        else $error("result bits 0 to 6 not zero");
    a_dw_legal: assert property (OP_VALID && OP_CODE inside {OP_WRD_DIR, OP_WRD_IDX}
        |=> OP_ILLEGAL == !(IMPL64 && DW_PRESENT))
        else $error("double-word write legality wrong");
    a_user_priv: assert property (OP_VALID && !OP_SUPER && OP_CODE <= OP_WR_IDX
        |=> OP_PRIV && !OP_ILLEGAL)
        else $error("user attempt not refused as privileged");
    a_wr32_back: assert property (OP_VALID && OP_CODE == OP_RD_DIR && OP_SUPER
        && $past(OP_VALID) && $past(OP_SUPER) && $past(OP_CODE) == OP_WR_DIR
        && $past(OP_SEG_INDEX) == OP_SEG_INDEX
        |=> OP_RESULT == ($past(OP_SOURCE_GPR, 2) & 64'h0000_0000_ffff_ffff))
        else $error("32-bit write not read back");
    a_wr64_back: assert property (IMPL64 && DW_PRESENT && OP_VALID && OP_SUPER
        && OP_CODE == OP_RD_DIR
        && $past(OP_VALID) && $past(OP_SUPER) && $past(OP_CODE) == OP_WRD_DIR
        && $past(OP_SEG_INDEX) == OP_SEG_INDEX
        |=> OP_RESULT == ($past(OP_SOURCE_GPR, 2) & 64'h01ff_ffff_ffff_ffff))
        else $error("double-word write not read back");
    a_victim_step: assert property (OP_VALID && OP_SUPER && OP_CODE == OP_WR_DIR
        |=> VICTIM_INDEX == $past(OP_SEG_INDEX) + 4'h1)
        else $error("replacement history not advanced by write");
endmodule : sgmv_checker
bind sgmv_seg_move sgmv_checker #(.IMPL64(IMPL64), .DW_PRESENT(DW_PRESENT)) chk (
    .CLOCK(CLOCK), .RST_N(RST_N), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
    .OP_SUPER(OP_SUPER), .OP_SEG_INDEX(OP_SEG_INDEX), .OP_SOURCE_GPR(OP_SOURCE_GPR),
    .OP_DONE(OP_DONE), .OP_RESULT(OP_RESULT), .OP_ILLEGAL(OP_ILLEGAL),
    .OP_PRIV(OP_PRIV), .VICTIM_INDEX(VICTIM_INDEX));

// ===== bench/sgmv_gpr_model.sv
// partner: register-file side that shapes source operands before issue
`timescale 1ns/1ns
module sgmv_gpr_model;
    // clear the fields software must leave zero, leave don't-care bits random
    function automatic logic [63:0] shape(input logic [63:0] raw, input logic dw);
        logic [63:0] v;
        v = raw;
        if (dw) v[63:57] = 7'h00;
        if (!v[31]) v[27:24] = 4'h0;
        return v;
    endfunction : shape
endmodule : sgmv_gpr_model

// ===== bench/sgmv_seg_move_bench.sv
// testbench: directed and random traffic against a behavioural model
`timescale 1ns/1ns
module sgmv_seg_move_bench;
    import sgmv_pkg::*;
    logic CLOCK = '0, RST_N = '0, OP_VALID = '0, OP_SUPER = '0, RELOAD_TOUCH = '0;
    logic PSEL = '0, PENABLE = '0, PWRITE = '0, e;
    sgmv_op_t OP_CODE = OP_RD_DIR;
    logic [3:0] OP_SEG_INDEX = '0, RELOAD_INDEX = '0, VICTIM_INDEX, vic = '0;
    logic [63:0] OP_SOURCE_GPR = '0, OP_INDEX_GPR = '0, OP_RESULT, r = '0;
    logic [7:0] PADDR = '0;
    logic [31:0] PWDATA = '0, PRDATA, d;
    logic OP_DONE, OP_RESULT_DEFINED, OP_ILLEGAL, OP_PRIV, SEG_TABLE_VALID, PREADY;
    logic PSLVERR, IRQ, ill32, rk = 1'h1;
    logic [63:0] ent [16] = '{default: '0};
    logic [15:0] made = '0;
    logic [2:0] st = '0;
    logic [5:0] q_f [$];
    logic [63:0] q_r [$];
    logic [3:0] q_v [$];
    int fails = 0, n_compared = 0;
    integer seed = 32'hd001;
    sgmv_seg_move #(.IMPL64(1'b1), .DW_PRESENT(1'b1)) uut (
        .CLOCK(CLOCK), .RST_N(RST_N), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
        .OP_SUPER(OP_SUPER), .OP_SEG_INDEX(OP_SEG_INDEX), .OP_SOURCE_GPR(OP_SOURCE_GPR),
        .OP_INDEX_GPR(OP_INDEX_GPR), .OP_DONE(OP_DONE), .OP_RESULT(OP_RESULT),
        .OP_RESULT_DEFINED(OP_RESULT_DEFINED), .OP_ILLEGAL(OP_ILLEGAL), .OP_PRIV(OP_PRIV),
        .RELOAD_TOUCH(RELOAD_TOUCH), .RELOAD_INDEX(RELOAD_INDEX),
        .VICTIM_INDEX(VICTIM_INDEX), .SEG_TABLE_VALID(SEG_TABLE_VALID), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ));
    // a 32-bit build on the same stimulus must refuse every double-word write
    sgmv_seg_move #(.IMPL64(1'b0), .DW_PRESENT(1'b1)) uut32 (
        .CLOCK(CLOCK), .RST_N(RST_N), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
        .OP_SUPER(OP_SUPER), .OP_SEG_INDEX(OP_SEG_INDEX), .OP_SOURCE_GPR(OP_SOURCE_GPR),
        .OP_INDEX_GPR(OP_INDEX_GPR), .OP_DONE(), .OP_RESULT(), .OP_RESULT_DEFINED(),
        .OP_ILLEGAL(ill32), .OP_PRIV(), .RELOAD_TOUCH(RELOAD_TOUCH),
        .RELOAD_INDEX(RELOAD_INDEX), .VICTIM_INDEX(), .SEG_TABLE_VALID(), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(), .PREADY(), .PSLVERR(), .IRQ());
    sgmv_gpr_model pm ();
    // compare one value, count it, report a mismatch
    task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask : chk
    // verdict and end of run
    task automatic conclude();
        if (fails == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    // outputs seen at this edge belong to the op issued two edges ago
    task automatic check();
        logic [5:0] f;
        f = q_f.pop_front();
        chk("done", f[4], OP_DONE);
        chk("illegal", f[3], OP_ILLEGAL);
        chk("illegal 32-bit", f[5], ill32);
        chk("privilege", f[2], OP_PRIV);
        if (f[1]) chk("defined", f[0], OP_RESULT_DEFINED);
        if (f[0]) chk("result", q_r[0], OP_RESULT);
        chk("victim", q_v[0], VICTIM_INDEX);
        void'(q_r.pop_front());
        void'(q_v.pop_front());
    endtask : check
    // issue one op cycle and advance the model
    task automatic op(logic v, logic [2:0] c, logic s, logic [3:0] si, logic [63:0] src,
        logic [63:0] ix, logic rt, logic [3:0] ri);
        logic [3:0] sel;
        logic ill, pr, rd, wr;
        @(posedge CLOCK);
        if (q_f.size() == 2) check();
        OP_VALID <= v;
        OP_CODE <= sgmv_op_t'(c);
        OP_SUPER <= s;
        OP_SEG_INDEX <= si;
        OP_SOURCE_GPR <= src;
        OP_INDEX_GPR <= ix;
        RELOAD_TOUCH <= rt;
        RELOAD_INDEX <= ri;
        sel = c[0] ? ix[31:28] : si;
        ill = v && c > 3'h5;
        pr = v && !ill && !s;
        rd = v && !ill && !pr && c < 3'h2;
        wr = v && !ill && !pr && c > 3'h1;
        if (rd) r = ent[sel];
        if (rd) rk = made[sel];
        st = st | {rd && !made[sel], pr, ill};
        if (wr) ent[sel] = src & (c[2] ? 64'h01ff_ffff_ffff_ffff : 64'hffff_ffff);
        if (wr) made[sel] = 1'h1;
        if (wr || rt) vic = (wr ? sel : ri) + 4'h1;
        q_f.push_back({v && c > 3'h3, v, ill, pr, rd, rk});
        q_r.push_back(r);
        q_v.push_back(vic);
    endtask : op
    // one apb transfer, read data and error left in d and e
    task automatic apb(logic w, logic [7:0] a, logic [31:0] wd);
        @(posedge CLOCK);
        PSEL <= 1'h1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLOCK);
        PENABLE <= 1'h1;
        // the wait ends on the first edge with PREADY high
        do begin
            @(posedge CLOCK);
        end while (PREADY !== 1'h1);
        d = PRDATA;
        e = PSLVERR;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
    endtask : apb
    // free-running clock
    initial begin
        forever #10 CLOCK = ~CLOCK;
    end
    // hang guard
    initial begin
        repeat (6000) @(posedge CLOCK);
        fails++;
        conclude();
    end
    // main sequence
    initial begin
        logic [2:0] c;
        repeat (8) @(posedge CLOCK);
        RST_N <= 1'h1;
        for (int a = 0; a < 20; a += 4) begin
            apb(1'h0, 8'(a), '0);
            chk("reset reg", 0, d);
        end
        op(1, 3'h2, 1, 4'h5, 64'hdead_beef_a5a5_0f0f, 0, 1, 4'h2);
        op(1, 3'h0, 1, 4'h5, 0, 0, 0, 0);
        op(1, 3'h4, 1, 4'h9, pm.shape(64'h0123_4567_89ab_cdef, 1), 0, 0, 0);
        op(1, 3'h0, 1, 4'h9, 0, 0, 0, 0);
        op(1, 3'h5, 1, 0, 64'h01ff_ffff_ffff_ffff, 64'hf000_0000, 0, 0);
        op(1, 3'h1, 1, 0, 0, 64'hf000_0000, 0, 0);
        repeat (400) begin
            c = 3'($random(seed));
            op(1'($random(seed) % 4 != 0), c, 1'($random(seed) % 5 != 0), 4'($random(seed)),
                pm.shape({$random(seed), $random(seed)}, c[2]),
                {$random(seed), $random(seed)}, 1'($random(seed) % 3 == 0), 4'($random(seed)));
        end
        repeat (2) op(0, 0, 0, 0, 0, 0, 0, 0);
        apb(1'h0, ADDR_STATUS, '0);
        chk("status", st, d);
        apb(1'h1, ADDR_MASK, 32'h0000_0007);
        apb(1'h0, ADDR_VICTIM, '0);
        chk("victim reg", vic, d);
        chk("irq", st != 0, IRQ);
        apb(1'h1, ADDR_STATUS, 32'(st));
        st = '0;
        apb(1'h0, ADDR_CREATED, '0);
        chk("created", made, d);
        chk("irq", 0, IRQ);
        apb(1'h1, ADDR_CTRL, 32'h0000_0001);
        apb(1'h0, ADDR_CTRL, '0);
        chk("ctrl", 1, d);
        chk("table valid", 1, SEG_TABLE_VALID);
        apb(1'h1, ADDR_CTRL, '0);
        made = '0;
        op(1, 3'h0, 1, 4'h5, 0, 0, 0, 0);
        repeat (2) op(0, 0, 0, 0, 0, 0, 0, 0);
        apb(1'h0, ADDR_STATUS, '0);
        chk("status", st, d);
        chk("irq", 1, IRQ);
        apb(1'h1, 8'h20, 32'hffff_ffff);
        chk("slverr", 1, e);
        apb(1'h0, 8'h20, '0);
        chk("unmapped", 0, d);
        conclude();
    end
endmodule : sgmv_seg_move_bench
